// File: verilog/euh_defines.svh
`ifndef EUH_DEFINES_SVH
`define EUH_DEFINES_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define EUH_OFS_WINDOW 8'h00
`define EUH_OFS_IER    8'h04
`define EUH_OFS_FCR    8'h08
`define EUH_OFS_LCR    8'h0C
`define EUH_OFS_MCR    8'h10
`define EUH_OFS_LSR    8'h14
`define EUH_OFS_PRESC  8'h18
`define EUH_OFS_ISR    8'h1C
`define EUH_OFS_IMR    8'h20
`define EUH_OFS_PINCFG 8'h24

// ----------------------------------------
// field positions
// ----------------------------------------
`define EUH_IER_RESET  7
`define EUH_IER_MODOE  6
`define EUH_IER_RTHI   5
`define EUH_IER_RTLO   4
`define EUH_LCR_DLS    7
`define EUH_FCR_EN     0
`define EUH_FCR_RCLR   1
`define EUH_FCR_TCLR   2
`define EUH_MCR_DTR    0
`define EUH_MCR_RTS    1
`define EUH_MCR_HALF   7
`define EUH_PIN_CS     0
`define EUH_PIN_AL     1
`define EUH_PIN_LCK    2

// ----------------------------------------
// reset values and counts
// ----------------------------------------
`define EUH_RST_IER    8'h00
`define EUH_RST_LCR    8'h00
`define EUH_RST_MCR    8'h00
`define EUH_RST_DLL    8'h00
`define EUH_RST_DLM    8'h80
`define EUH_RST_PRESC  8'h00
`define EUH_FIFO_DEPTH 4'h8
`define EUH_TX_LAST    4'h9
`define EUH_RX_LAST    4'h7
`define EUH_RESP_OKAY  2'h0
`define EUH_RESP_SLVER 2'h2

`endif

// File: verilog/euh_pkg.sv
package euh_pkg;

   typedef enum logic [1:0] {
      ROUTE_P2   = 2'b00,
      ROUTE_P4   = 2'b01,
      ROUTE_XCVR = 2'b10
   } euh_route_t;

   typedef enum logic [1:0] {
      IND_NONE = 2'b00,
      IND_P25  = 2'b01,
      IND_P44  = 2'b10
   } euh_ind_t;

   typedef enum logic [1:0] {
      TX_IDLE = 2'b00,
      TX_LOAD = 2'b01,
      TX_SEND = 2'b10
   } euh_tx_st_t;

   typedef enum logic [1:0] {
      RX_IDLE  = 2'b00,
      RX_START = 2'b01,
      RX_DATA  = 2'b10,
      RX_STOP  = 2'b11
   } euh_rx_st_t;

   typedef struct packed {
      logic p27_o;
      logic p27_oe;
      logic p44_o;
      logic p44_oe;
      logic p25_o;
      logic p25_oe;
      logic xcvr_tx_o;
      logic xcvr_de_o;
   } euh_pins_o_t;

   typedef struct packed {
      logic p26_i;
      logic p40_i;
      logic xcvr_rx_i;
   } euh_pins_i_t;

   typedef struct packed {
      logic rts_n;
      logic dtr_n;
      logic oe;
   } euh_modem_o_t;

endpackage

// File: verilog/euh_fifo.sv
`timescale 1ns/1ns
`include "euh_defines.svh"

module euh_fifo
   import euh_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic       sys_rst,
   input  wire logic       clr,
   input  wire logic       one_deep,
   input  wire logic       push,
   input  wire logic [7:0] push_data,
   input  wire logic       pop,
   output logic            full,
   output logic            empty,
   output logic [7:0]      rd_data
);

   logic [7:0] mem_q [8];
   logic [2:0] wr_ptr_q;
   logic [2:0] rd_ptr_q;
   logic [3:0] cnt_q;
   logic [7:0] rd_data_q;
   logic       do_push;
   logic       do_pop;

   // one_deep models the plain holding register
   assign full    = one_deep ? (cnt_q != 4'h0)
                             : (cnt_q == `EUH_FIFO_DEPTH);
   assign empty   = (cnt_q == 4'h0);
   assign do_push = push & ~full;
   assign do_pop  = pop & ~empty;
   assign rd_data = rd_data_q;

   always_ff @(posedge clk_sys) begin
      if (do_push) mem_q[wr_ptr_q] <= push_data;
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         wr_ptr_q  <= 3'h0;
         rd_ptr_q  <= 3'h0;
         cnt_q     <= 4'h0;
         rd_data_q <= 8'h00;
      end else if (clr) begin
         wr_ptr_q <= 3'h0;
         rd_ptr_q <= 3'h0;
         cnt_q    <= 4'h0;
      end else begin
         if (do_push) wr_ptr_q <= wr_ptr_q + 3'h1;
         if (do_pop) rd_ptr_q <= rd_ptr_q + 3'h1;
         if (do_pop) rd_data_q <= mem_q[rd_ptr_q];
         cnt_q <= cnt_q + {3'h0, do_push} - {3'h0, do_pop};
      end
   end

endmodule // euh_fifo

// File: verilog/euh_pinroute.sv
`timescale 1ns/1ns

module euh_pinroute
   import euh_pkg::*;
(
   input  wire logic route_hi,
   input  wire logic route_lo,
   input  wire logic cs_oe,
   input  wire logic al_oe,
   input  wire logic lck_oe,
   output logic      term,
   output euh_route_t route,
   output euh_ind_t  ind
);

   assign term = ~((cs_oe & ~al_oe) | lck_oe);

   // ----------------------------------------
   // route table
   // ----------------------------------------
   always_comb begin
      unique case ({term, route_hi, route_lo})
         3'b000, 3'b100: begin
            route = ROUTE_P2;
            ind   = IND_NONE;
         end
         3'b010: begin
            route = ROUTE_P4;
            ind   = IND_NONE;
         end
         3'b001: begin
            route = ROUTE_P2;
            ind   = IND_P25;
         end
         3'b011: begin
            route = ROUTE_XCVR;
            ind   = IND_NONE;
         end
         3'b110: begin
            route = ROUTE_XCVR;
            ind   = IND_P44;
         end
         3'b101: begin
            route = ROUTE_XCVR;
            ind   = IND_P25;
         end
         3'b111: begin
            route = ROUTE_P2;
            ind   = IND_NONE;
         end
      endcase
   end

endmodule // euh_pinroute

// File: verilog/euh_top.sv
// The AXI4-Lite slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`include "euh_defines.svh"

// Functional notes
// - window and IER only with select clear
// - window reads receive, writes transmit
// - received bytes pass through receive FIFO
// - written bytes queue, sent in order
// - IER bit 7 soft reset, self clearing
// - IER bit 6 gates RTS and DTR
// - IER bits 3..0 enable interrupt sources
// - route from two bits plus term
// - term is inverted bus enable combination
// - routes with term zero
// - routes with term one
// - transceiver routes drive differential pads
// - select set reaches divisor and prescaler
// - FCR bit 0 enables both FIFOs
module euh_top
   import euh_pkg::*;
(
   input  wire logic         clk_sys,
   input  wire logic         sys_rst,
   input  wire logic [7:0]   s_axi_awaddr,
   input  wire logic         s_axi_awvalid,
   output logic              s_axi_awready,
   input  wire logic [31:0]  s_axi_wdata,
   input  wire logic [3:0]   s_axi_wstrb,
   input  wire logic         s_axi_wvalid,
   output logic              s_axi_wready,
   output logic [1:0]        s_axi_bresp,
   output logic              s_axi_bvalid,
   input  wire logic         s_axi_bready,
   input  wire logic [7:0]   s_axi_araddr,
   input  wire logic         s_axi_arvalid,
   output logic              s_axi_arready,
   output logic [31:0]       s_axi_rdata,
   output logic [1:0]        s_axi_rresp,
   output logic              s_axi_rvalid,
   input  wire logic         s_axi_rready,
   input  wire euh_pins_i_t  pins_i,
   output euh_pins_o_t       pins_o,
   input  wire logic         cts_i,
   input  wire logic         dsr_i,
   output euh_modem_o_t      modem_o,
   output logic              irq
);

   logic [7:0]   ier_q, lcr_q, mcr_q, dll_q, dlm_q, presc_q, pincfg_q, wd;
   logic [7:0]   rd_mux, rxf_data, txf_data, lsr, rx_sh_q, psc_cnt_q;
   logic [7:0]   awaddr_q, araddr_q, rd_tab [16];
   logic [3:0]   isr_q, imr_q, ev, isr_d, tx_n_q, rx_n_q;
   logic [9:0]   wsel, tx_sh_q;
   logic [1:0]   bresp_q, rresp_q;
   logic [31:0]  rdata_q;
   logic [15:0]  tx_cnt_q, rx_cnt_q, div_raw, div_m1, div_half;
   logic         fifo_en_q, soft_q, oe_q, fe_q, rclr_q, tclr_q, cts_q, dsr_q;
   logic         txe_q, awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
   logic         rpend_q, aw_have_q, w_have_q, wstrb0_q, irq_q, aw_take;
   logic         w_take, ar_take, do_wr, wr_en, aw_have_d, w_have_d;
   logic         bvalid_d, rvalid_d, dls, wa_err, ra_err, clr_isr, clr_lsr;
   logic         rxf_full, rxf_empty, rxf_pop, rxf_push, txf_full, txf_empty;
   logic         txf_pop, txf_push, term, tx_line, tx_act, rx_in, rx_done;
   logic         tick;
   euh_pins_o_t  pins_q, pins_d;
   euh_modem_o_t modem_q;
   euh_route_t   route;
   euh_ind_t     ind;
   euh_tx_st_t   tx_st_q;
   euh_rx_st_t   rx_st_q;

   // ----------------------------------------
   // bus handshakes and decode
   // ----------------------------------------
   assign aw_take   = s_axi_awvalid & awready_q;
   assign w_take    = s_axi_wvalid & wready_q;
   assign ar_take   = s_axi_arvalid & arready_q;
   assign do_wr     = aw_have_q & w_have_q & ~bvalid_q;
   assign wr_en     = do_wr & wstrb0_q;
   assign aw_have_d = (aw_have_q & ~do_wr) | aw_take;
   assign w_have_d  = (w_have_q & ~do_wr) | w_take;
   assign bvalid_d  = (bvalid_q & ~s_axi_bready) | do_wr;
   assign rvalid_d  = (rvalid_q & ~s_axi_rready) | rpend_q;

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         {awready_q, wready_q, arready_q} <= 3'h7;
         {aw_have_q, w_have_q, bvalid_q, rvalid_q, rpend_q} <= 5'h00;
      end else begin
         {aw_have_q, w_have_q, bvalid_q} <= {aw_have_d, w_have_d, bvalid_d};
         awready_q <= ~aw_have_d & ~bvalid_d;
         wready_q  <= ~w_have_d & ~bvalid_d;
         rpend_q   <= ar_take;
         rvalid_q  <= rvalid_d;
         arready_q <= ~ar_take & ~rvalid_d;
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         {awaddr_q, araddr_q, wd} <= 24'h000000;
         {bresp_q, rresp_q} <= {`EUH_RESP_OKAY, `EUH_RESP_OKAY};
         wstrb0_q <= 1'h0;
         rdata_q  <= 32'h00000000;
      end else begin
         if (aw_take) awaddr_q <= s_axi_awaddr;
         if (w_take) wd <= s_axi_wdata[7:0];
         if (w_take) wstrb0_q <= s_axi_wstrb[0];
         if (ar_take) araddr_q <= s_axi_araddr;
         if (do_wr) bresp_q <= wa_err ? `EUH_RESP_SLVER
                                      : `EUH_RESP_OKAY;
         if (rpend_q) rresp_q <= ra_err ? `EUH_RESP_SLVER
                                        : `EUH_RESP_OKAY;
         if (rpend_q) rdata_q <= {24'h000000, rd_mux};
      end
   end

   assign dls     = lcr_q[`EUH_LCR_DLS];
   assign wa_err  = (awaddr_q[1:0] != 2'h0) | (awaddr_q > `EUH_OFS_PINCFG);
   assign ra_err  = (araddr_q[1:0] != 2'h0) | (araddr_q > `EUH_OFS_PINCFG);
   // one-hot select of a write, indexed by word offset
   assign wsel    = (wr_en & ~wa_err) ? 10'h001 << awaddr_q[5:2] : 10'h000;
   assign clr_isr = rpend_q & (araddr_q == `EUH_OFS_ISR);
   assign clr_lsr = rpend_q & (araddr_q == `EUH_OFS_LSR);
   assign lsr = {1'h0, txf_empty & ~tx_act, txf_empty, 1'h0,
                 fe_q, 1'h0, oe_q, ~rxf_empty};
   // read values by word offset
   assign rd_tab[0] = dls ? dll_q : rxf_data;
   assign rd_tab[1] = dls ? dlm_q : {soft_q, ier_q[6:0]};
   assign rd_tab[2] = {{2{fifo_en_q}}, 5'h00, ~irq_q};
   assign rd_tab[3] = lcr_q;
   assign rd_tab[4] = mcr_q;
   assign rd_tab[5] = lsr;
   assign rd_tab[6] = dls ? presc_q : 8'h00;
   assign rd_tab[7] = {4'h0, isr_q};
   assign rd_tab[8] = {4'h0, imr_q};
   assign rd_tab[9] = pincfg_q;
   for (genvar i = 10; i < 16; i++) begin : g_rd_pad
      assign rd_tab[i] = 8'h00;
   end
   assign rd_mux = ra_err ? 8'h00 : rd_tab[araddr_q[5:2]];

   // ----------------------------------------
   // control registers and FIFOs
   // ----------------------------------------
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         {ier_q, lcr_q, mcr_q} <= {`EUH_RST_IER, `EUH_RST_LCR, `EUH_RST_MCR};
         {dll_q, dlm_q} <= {`EUH_RST_DLL, `EUH_RST_DLM};
         presc_q <= `EUH_RST_PRESC;
         {imr_q, pincfg_q} <= 12'h000;
         {fifo_en_q, soft_q, rclr_q, tclr_q} <= 4'h0;
      end else begin
         soft_q <= wsel[1] & ~dls & wd[`EUH_IER_RESET];
         rclr_q <= wsel[2] & wd[`EUH_FCR_RCLR];
         tclr_q <= wsel[2] & wd[`EUH_FCR_TCLR];
         if (wsel[1] & ~dls) ier_q <= {1'h0, wd[6:0]};
         if (wsel[1] & dls) dlm_q <= wd;
         if (wsel[0] & dls) dll_q <= wd;
         if (wsel[6] & dls) presc_q <= wd;
         if (wsel[2]) fifo_en_q <= wd[`EUH_FCR_EN];
         if (wsel[3]) lcr_q <= wd;
         if (wsel[4]) mcr_q <= wd;
         if (wsel[8]) imr_q <= wd[3:0];
         if (wsel[9]) pincfg_q <= {5'h00, wd[2:0]};
      end
   end

   assign txf_push = wsel[0] & ~dls;
   assign txf_pop  = (tx_st_q == TX_IDLE) & ~txf_empty & ~soft_q;
   assign rxf_pop  = ar_take & (s_axi_araddr == `EUH_OFS_WINDOW)
                     & ~dls;
   assign rxf_push = rx_done & ~rxf_full;

   euh_fifo u_txf (
      .clk_sys   (clk_sys),
      .sys_rst   (sys_rst),
      .clr       (soft_q | tclr_q),
      .one_deep  (~fifo_en_q),
      .push      (txf_push),
      .push_data (wd),
      .pop       (txf_pop),
      .full      (txf_full),
      .empty     (txf_empty),
      .rd_data   (txf_data)
   );

   euh_fifo u_rxf (
      .clk_sys   (clk_sys),
      .sys_rst   (sys_rst),
      .clr       (soft_q | rclr_q),
      .one_deep  (~fifo_en_q),
      .push      (rxf_push),
      .push_data (rx_sh_q),
      .pop       (rxf_pop),
      .full      (rxf_full),
      .empty     (rxf_empty),
      .rd_data   (rxf_data)
   );

   assign div_raw  = {dlm_q, dll_q};
   assign div_m1   = (div_raw == 16'h0000) ? 16'h0000
                                           : div_raw - 16'h0001;
   assign div_half = {1'h0, div_m1[15:1]};
   assign tick     = (psc_cnt_q == presc_q);

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) psc_cnt_q <= 8'h00;
      else psc_cnt_q <= tick ? 8'h00 : psc_cnt_q + 8'h01;
   end

   // ----------------------------------------
   // transmitter
   // ----------------------------------------
   assign tx_line = tx_sh_q[0];
   assign tx_act  = (tx_st_q != TX_IDLE);

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         tx_st_q  <= TX_IDLE;
         tx_sh_q  <= 10'h3FF;
         tx_n_q   <= 4'h0;
         tx_cnt_q <= 16'h0000;
      end else if (soft_q) begin
         tx_st_q  <= TX_IDLE;
         tx_sh_q  <= 10'h3FF;
      end else begin
         unique case (tx_st_q)
            TX_IDLE: if (!txf_empty) tx_st_q <= TX_LOAD;
            TX_LOAD: begin
               tx_sh_q  <= {1'h1, txf_data, 1'h0};
               tx_n_q   <= 4'h0;
               tx_cnt_q <= 16'h0000;
               tx_st_q  <= TX_SEND;
            end
            TX_SEND: if (tick) begin
               if (tx_cnt_q == div_m1) begin
                  tx_cnt_q <= 16'h0000;
                  tx_sh_q  <= {1'h1, tx_sh_q[9:1]};
                  tx_n_q   <= tx_n_q + 4'h1;
                  if (tx_n_q == `EUH_TX_LAST) tx_st_q <= TX_IDLE;
               end else begin
                  tx_cnt_q <= tx_cnt_q + 16'h0001;
               end
            end
            default: tx_st_q <= TX_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // receiver
   // ----------------------------------------
   assign rx_done = (rx_st_q == RX_STOP) & tick & (rx_cnt_q == div_m1);

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         rx_st_q  <= RX_IDLE;
         rx_sh_q  <= 8'h00;
         rx_n_q   <= 4'h0;
         rx_cnt_q <= 16'h0000;
      end else if (soft_q) begin
         rx_st_q  <= RX_IDLE;
      end else begin
         unique case (rx_st_q)
            RX_IDLE: if (!rx_in) begin
               rx_cnt_q <= 16'h0000;
               rx_st_q  <= RX_START;
            end
            RX_START: if (tick) begin
               if (rx_cnt_q == div_half) begin
                  rx_cnt_q <= 16'h0000;
                  rx_n_q   <= 4'h0;
                  rx_st_q  <= rx_in ? RX_IDLE : RX_DATA;
               end else begin
                  rx_cnt_q <= rx_cnt_q + 16'h0001;
               end
            end
            RX_DATA: if (tick) begin
               if (rx_cnt_q == div_m1) begin
                  rx_cnt_q <= 16'h0000;
                  rx_sh_q  <= {rx_in, rx_sh_q[7:1]};
                  rx_n_q   <= rx_n_q + 4'h1;
                  if (rx_n_q == `EUH_RX_LAST) rx_st_q <= RX_STOP;
               end else begin
                  rx_cnt_q <= rx_cnt_q + 16'h0001;
               end
            end
            RX_STOP: if (tick) begin
               if (rx_cnt_q == div_m1) rx_st_q <= RX_IDLE;
               else rx_cnt_q <= rx_cnt_q + 16'h0001;
            end
         endcase
      end
   end

   // ----------------------------------------
   // status and interrupt
   // ----------------------------------------
   assign ev[0] = rxf_push;
   assign ev[1] = txf_empty & ~txe_q;
   assign ev[2] = rx_done & (rxf_full | ~rx_in);
   assign ev[3] = (cts_i != cts_q) | (dsr_i != dsr_q);
   assign isr_d = (isr_q & ~{4{clr_isr}}) | ev; // set wins over read

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         {isr_q, oe_q, fe_q} <= 6'h00;
         {txe_q, cts_q, dsr_q, irq_q} <= 4'h8;
      end else begin
         isr_q <= soft_q ? 4'h0 : isr_d;
         oe_q  <= ~soft_q & ((oe_q & ~clr_lsr) | (rx_done & rxf_full));
         fe_q  <= ~soft_q & ((fe_q & ~clr_lsr) | (rx_done & ~rx_in));
         txe_q <= txf_empty;
         {cts_q, dsr_q} <= {cts_i, dsr_i};
         irq_q <= |(isr_q & imr_q & ier_q[3:0]);
      end
   end

   // ----------------------------------------
   // pin routing
   // ----------------------------------------
   euh_pinroute u_route (
      .route_hi (ier_q[`EUH_IER_RTHI]),
      .route_lo (ier_q[`EUH_IER_RTLO]),
      .cs_oe    (pincfg_q[`EUH_PIN_CS]),
      .al_oe    (pincfg_q[`EUH_PIN_AL]),
      .lck_oe   (pincfg_q[`EUH_PIN_LCK]),
      .term     (term),
      .route    (route),
      .ind      (ind)
   );

   // own echo on the shared pair is masked in half duplex
   assign rx_in = (route == ROUTE_P4)   ? pins_i.p40_i :
                  (route == ROUTE_XCVR) ? (pins_i.xcvr_rx_i |
                     (mcr_q[`EUH_MCR_HALF] & tx_act)) :
                  pins_i.p26_i;

   assign pins_d.p27_o     = tx_line;
   assign pins_d.p27_oe    = (route == ROUTE_P2);
   assign pins_d.p44_o     = (route == ROUTE_P4) ? tx_line : tx_act;
   assign pins_d.p44_oe    = (route == ROUTE_P4) | (ind == IND_P44);
   assign pins_d.p25_o     = tx_act;
   assign pins_d.p25_oe    = (ind == IND_P25);
   assign pins_d.xcvr_tx_o = tx_line;
   assign pins_d.xcvr_de_o = (route == ROUTE_XCVR) & tx_act;

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         pins_q  <= euh_pins_o_t'(8'h00);
         modem_q <= euh_modem_o_t'(3'h6);
      end else begin
         pins_q        <= pins_d;
         modem_q.oe    <= ier_q[`EUH_IER_MODOE];
         modem_q.rts_n <= ~(ier_q[`EUH_IER_MODOE] &
                            mcr_q[`EUH_MCR_RTS]);
         modem_q.dtr_n <= ~(ier_q[`EUH_IER_MODOE] &
                            mcr_q[`EUH_MCR_DTR]);
      end
   end

   assign {s_axi_awready, s_axi_wready, s_axi_arready} =
          {awready_q, wready_q, arready_q};
   assign {s_axi_bresp, s_axi_bvalid} = {bresp_q, bvalid_q};
   assign {s_axi_rdata, s_axi_rresp, s_axi_rvalid} =
          {rdata_q, rresp_q, rvalid_q};
   assign {pins_o, modem_o, irq} = {pins_q, modem_q, irq_q};

endmodule // euh_top

// File: tb/euh_top_properties.sv
`timescale 1ns/1ns
module euh_top_properties
   import euh_pkg::*;
(
   input wire logic        clk_sys,
   input wire logic        sys_rst,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready
);
   // ----------------------------------------
   // register bus timing
   // ----------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   AST_WR_ANSWER: assert property (s_axi_awvalid && s_axi_awready &&
      s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid) else $error("no b");
   AST_B_STANDS: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("b dropped");
   AST_AW_HELD: assert property (s_axi_bvalid |-> !s_axi_awready)
      else $error("aw open");
   AST_AW_REOPEN: assert property (s_axi_bvalid && s_axi_bready
      |=> s_axi_awready) else $error("aw closed");
   AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready
      |=> !s_axi_arready ##1 s_axi_rvalid) else $error("no r");
   AST_R_STANDS: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("r dropped");
   AST_R_BYTE: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 0)
      else $error("rdata high");
   AST_R_ERR: assert property (s_axi_rvalid && s_axi_rresp == 2'h2
      |-> s_axi_rdata == 32'h0) else $error("err data");
endmodule // euh_top_properties
bind euh_top euh_top_properties u_props (.clk_sys(clk_sys),
   .sys_rst(sys_rst), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// File: tb/euh_echo_node.sv
`timescale 1ns/1ns
module euh_echo_node #(
   parameter int BIT_CYC = 4
) (
   input  wire logic clk_sys,
   input  wire logic tx_line,
   output logic      rx_line,
   output int        echoed
);
   logic [7:0] got_q [$];
   logic [7:0] rx_d;
   logic [9:0] frame;
   // ----------------------------------------
   // capture 8N1 frames, then echo them back
   // ----------------------------------------
   initial begin
      @(posedge tx_line);
      forever begin
         @(negedge tx_line);
         repeat (BIT_CYC / 2) @(posedge clk_sys);
         for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYC) @(posedge clk_sys);
            rx_d[i] = tx_line;
         end
         repeat (BIT_CYC) @(posedge clk_sys);
         got_q.push_back(rx_d);
      end
   end
   initial begin
      rx_line = 1'h1;
      echoed = 0;
      forever begin
         @(posedge clk_sys);
         if (got_q.size() > 0) begin
            frame = {1'h1, got_q.pop_front(), 1'h0};
            for (int i = 0; i < 10; i++) begin
               rx_line <= frame[i];
               repeat (BIT_CYC) @(posedge clk_sys);
            end
            echoed++;
         end
      end
   end
endmodule // euh_echo_node

// File: tb/euh_top_tb_top.sv
`timescale 1ns/1ns
`include "euh_defines.svh"
module euh_top_tb_top
   import euh_pkg::*;
;
   logic         clk_sys = 1'h0, sys_rst = 1'h1, irq, s_axi_awready;
   logic         s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bvalid;
   logic         s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_rvalid;
   logic         s_axi_bready = 1'h0, s_axi_wready, s_axi_arready;
   logic [7:0]   s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, b [3];
   logic [31:0]  s_axi_wdata = 32'h0, s_axi_rdata;
   logic [1:0]   s_axi_bresp, s_axi_rresp;
   logic [33:0]  exp_q [$];
   euh_pins_o_t  pins_o;
   euh_modem_o_t modem_o;
   wire logic    rx_line;
   int           checks = 0, fail_count = 0;
   always #25 clk_sys = ~clk_sys;
   euh_top u_dut (.clk_sys, .sys_rst, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pins_i({rx_line, 2'h3}),
      .pins_o, .cts_i(1'h0), .dsr_i(1'h0), .modem_o, .irq);
   euh_echo_node #(.BIT_CYC(4)) u_node (.clk_sys, .tx_line(pins_o.p27_o),
      .rx_line, .echoed());
   // ----------------------------------------
   // checks and bus transfers
   // ----------------------------------------
   task automatic chk(input string n, input logic [33:0] e, g);
      checks++;
      if (e !== g) begin
         $display("MISMATCH %s exp %h got %h", n, e, g);
         fail_count++;
      end
   endtask
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [33:0] e);
      if (!w) exp_q.push_back(e);
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_araddr <= a;
      s_axi_wdata <= e[31:0];
      s_axi_awvalid <= w;
      s_axi_wvalid <= w;
      s_axi_arvalid <= !w;
      do @(posedge clk_sys);
      while (!(w ? s_axi_awready && s_axi_wready : s_axi_arready));
      s_axi_awvalid <= 1'h0;
      s_axi_wvalid <= 1'h0;
      s_axi_arvalid <= 1'h0;
      repeat ($urandom_range(2)) @(posedge clk_sys);
      s_axi_bready <= w;
      s_axi_rready <= !w;
      do @(posedge clk_sys); while (!(w ? s_axi_bvalid : s_axi_rvalid));
      if (w) chk("bresp", 34'h0, s_axi_bresp);
      s_axi_bready <= 1'h0;
      s_axi_rready <= 1'h0;
   endtask
   always @(posedge clk_sys) begin
      if (s_axi_rvalid && s_axi_rready && exp_q.size() > 0)
         chk("rdata", exp_q.pop_front(), {s_axi_rresp, s_axi_rdata});
   end
   task automatic close_out();
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk_sys);
      fail_count++;
      close_out();
   end
   initial begin
      void'($urandom(32'h6394eda5));
      repeat (10) @(posedge clk_sys);
      sys_rst <= 1'h0;
      xfer(1'h0, `EUH_OFS_IER, 34'h0);
      xfer(1'h0, 8'h3C, {2'h2, 32'h0});
      xfer(1'h1, `EUH_OFS_IER, 34'h01);
      xfer(1'h1, `EUH_OFS_LCR, 34'h80);
      xfer(1'h1, `EUH_OFS_IER, 34'h00);
      xfer(1'h0, `EUH_OFS_IER, 34'h0);
      xfer(1'h1, `EUH_OFS_WINDOW, 34'h04);
      xfer(1'h1, `EUH_OFS_LCR, 34'h00);
      xfer(1'h0, `EUH_OFS_IER, 34'h1);
      xfer(1'h1, `EUH_OFS_FCR, 34'h01);
      xfer(1'h1, `EUH_OFS_IMR, 34'h0F);
      for (int i = 0; i < 3; i++) begin
         b[i] = 8'($urandom);
         xfer(1'h1, `EUH_OFS_WINDOW, {26'h0, b[i]});
      end
      while (u_node.echoed < 3) @(posedge clk_sys);
      repeat (20) @(posedge clk_sys);
      chk("irq", 34'h1, irq);
      xfer(1'h1, `EUH_OFS_IER, 34'h00);
      repeat (3) @(posedge clk_sys);
      chk("irq", 34'h0, irq);
      for (int i = 0; i < 3; i++)
         xfer(1'h0, `EUH_OFS_WINDOW, {26'h0, b[i]});
      xfer(1'h1, `EUH_OFS_IER, 34'h80);
      xfer(1'h0, `EUH_OFS_IER, 34'h0);
      xfer(1'h1, `EUH_OFS_MCR, 34'h03);
      xfer(1'h1, `EUH_OFS_IER, 34'h40);
      repeat (2) @(posedge clk_sys);
      chk("modem", 34'h1, {modem_o.rts_n, modem_o.dtr_n, modem_o.oe});
      xfer(1'h1, `EUH_OFS_IER, 34'h00);
      repeat (2) @(posedge clk_sys);
      chk("modem_oe", 34'h0, modem_o.oe);
      for (int t = 0; t < 2; t++)
         for (int r = 0; r < 4; r++) begin
            xfer(1'h1, `EUH_OFS_PINCFG, t ? 34'h0 : 34'h1);
            xfer(1'h1, `EUH_OFS_IER, 34'(r << 4));
            repeat (2) @(posedge clk_sys);
            chk("route", {r == 0 || (t ? r == 3 : r == 1), r == 2},
                {pins_o.p27_oe, pins_o.p44_oe});
         end
      close_out();
   end
endmodule // euh_top_tb_top
